/* rtl/rss_cfg.svh */
// constants for the synthesizer setting sequencer
// assumes the includer works at the 80 MHz core clock
// Function
// - all pulses and delays count whole 12.5 ns core cycles
// - synthesizer clocked at 80 MHz, frequency held as 34-bit tuning word
// - phase held as 16-bit word spanning one full turn
// - amplitude modulator held as 16-bit word, about 96 dB range
// - power level held as 15-bit word, about 90 dB, 0.1 dB step
// - each step instruction takes 25 ns; programmer keeps that spacing
// - words load within one cycle; updates limited to one per 25 ns
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_CLK_PERIOD_PS 12500
`define RSS_STEP_TIME_PS  25000
`define RSS_STEP_CYCLES   (`RSS_STEP_TIME_PS / `RSS_CLK_PERIOD_PS)
`define RSS_FREQ_W        34
`define RSS_PHASE_W       16
`define RSS_AMP_W         16
`define RSS_PWR_W         15
`define RSS_AXI_FREQ_LO   8'h00
`define RSS_AXI_FREQ_HI   8'h04
`define RSS_AXI_PHASE     8'h08
`define RSS_AXI_AMP       8'h0C
`define RSS_AXI_PWR       8'h10
`define RSS_AXI_CTRL      8'h14
`define RSS_AXI_STAT      8'h18
`define RSS_AXI_SEL_LSB   1
`endif

/* rtl/rss_pkg.sv */
// types for the synthesizer setting sequencer
// assumes rss_cfg.svh for widths
`include "rss_cfg.svh"
package rss_pkg;
  typedef logic [`RSS_FREQ_W-1:0]  rss_freq_t;
  typedef logic [`RSS_PHASE_W-1:0] rss_phase_t;
  typedef logic [`RSS_AMP_W-1:0]   rss_amp_t;
  typedef logic [`RSS_PWR_W-1:0]   rss_pwr_t;
  typedef logic [1:0]              rss_gap_t;
  typedef struct packed {
    rss_freq_t  freq;
    rss_phase_t phase;
    rss_amp_t   amp;
    rss_pwr_t   pwr;
  } rss_set_t;
  typedef struct packed {
    rss_set_t    stage;      // software staging words
    rss_set_t    live;       // words seen by the synthesizer
    rss_gap_t    gap;        // cycles left before next apply
    logic [15:0] apply_cnt;  // applied events
    logic [15:0] drop_cnt;   // events refused for spacing
    logic        awv;
    logic [7:0]  awaddr;
    logic        wv;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
  } rss_state_t;
endpackage

/* rtl/rss_sequencer.sv */
// setting sequencer: stages synthesizer words over axi4-lite and
// applies them atomically on timed events from the pulse programmer
// assumes one 80 MHz clock; event input synchronous to it
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rss_cfg.svh"
module rss_sequencer (
  input  wire logic              aclk,           // 80 MHz core clock
  input  wire logic              aresetn,        // sync reset, low
  input  wire logic              event_strobe,   // setting event pulse
  input  wire rss_pkg::rss_set_t event_words,    // words with the event
  input  wire logic              event_use_link, // take event words
  output logic                   event_busy,     // spacing window open
  output rss_pkg::rss_freq_t     freq_word,      // tuning word
  output rss_pkg::rss_phase_t    phase_word,     // phase word
  output rss_pkg::rss_amp_t      amplitude_modulator_word, // modulator
  output rss_pkg::rss_pwr_t      power_level_word, // power level
  output logic                   apply_pulse,    // words just changed
  input  wire logic [7:0]        s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write addr valid
  output logic                   s_axi_awready,  // write addr ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // byte enables
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // response valid
  input  wire logic              s_axi_bready,   // response ready
  input  wire logic [7:0]        s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read addr valid
  output logic                   s_axi_arready,  // read addr ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read valid
  input  wire logic              s_axi_rready    // read ready
);
  import rss_pkg::*;

  // spacing window: the step time in core cycles, less the apply cycle;
  // the counter only ever loads this value and counts down to zero
  localparam rss_gap_t GAP = rss_gap_t'(`RSS_STEP_CYCLES - 1);

  rss_state_t r;
  rss_state_t next_r;
  logic       sw_apply;
  logic       fire;

  // handshake outputs
  // aw and w stall while a response waits, so one write at a time
  assign s_axi_awready = !r.awv && !r.bvalid;
  assign s_axi_wready  = !r.wv && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign event_busy    = (r.gap != 2'h0);
  assign freq_word     = r.live.freq;
  assign phase_word    = r.live.phase;
  assign amplitude_modulator_word = r.live.amp;
  assign power_level_word = r.live.pwr;
  // high in the first cycle that shows freshly applied words
  assign apply_pulse   = (r.gap == GAP);

  // byte-lane merge of write data
  // lanes left out read as zero, not as the old staged value
  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  st);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction

  // next-state logic: bus slave, staging, timed apply
  always_comb begin
    next_r   = r;
    sw_apply = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.awv    = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.wv    = 1'b1;
      next_r.wdata = lane(32'h0, s_axi_wdata, s_axi_wstrb);
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // both halves held: perform write
    if (r.awv && r.wv) begin
      next_r.awv    = 1'b0;
      next_r.wv     = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = 2'h0;
      unique case (r.awaddr)
        `RSS_AXI_FREQ_LO: next_r.stage.freq[31:0] = r.wdata;
        `RSS_AXI_FREQ_HI: next_r.stage.freq[33:32] = r.wdata[1:0];
        `RSS_AXI_PHASE:   next_r.stage.phase = r.wdata[15:0];
        `RSS_AXI_AMP:     next_r.stage.amp = r.wdata[15:0];
        `RSS_AXI_PWR:     next_r.stage.pwr = r.wdata[14:0];
        `RSS_AXI_CTRL:    sw_apply = r.wdata[0];
        `RSS_AXI_STAT:    next_r.bresp = 2'h2;
        default:          next_r.bresp = 2'h2;
      endcase
    end
    // event apply, spaced by the step time
    fire = (event_strobe || sw_apply) && (r.gap == 2'h0);
    if (r.gap != 2'h0) begin
      next_r.gap = r.gap - 2'h1;
    end
    if (fire) begin
      next_r.live = (event_strobe && event_use_link) ? event_words
                                                     : r.stage;
      next_r.gap       = GAP;
      next_r.apply_cnt = r.apply_cnt + 16'h1;
    end else if ((event_strobe || sw_apply) && r.gap != 2'h0) begin
      next_r.drop_cnt = r.drop_cnt + 16'h1;
    end
    // read channel
    // reads show the live words, not the staged ones
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = 2'h0;
      unique case (s_axi_araddr)
        `RSS_AXI_FREQ_LO: next_r.rdata = r.live.freq[31:0];
        `RSS_AXI_FREQ_HI: next_r.rdata = {30'h0, r.live.freq[33:32]};
        `RSS_AXI_PHASE:   next_r.rdata = {16'h0, r.live.phase};
        `RSS_AXI_AMP:     next_r.rdata = {16'h0, r.live.amp};
        `RSS_AXI_PWR:     next_r.rdata = {17'h0, r.live.pwr};
        `RSS_AXI_CTRL:    next_r.rdata = {31'h0, event_busy};
        `RSS_AXI_STAT:    next_r.rdata = {r.drop_cnt, r.apply_cnt};
        default: begin
          next_r.rdata = 32'h0;
          next_r.rresp = 2'h2;
        end
      endcase
    end
    // sync reset last, so it overrides every update above
    if (!aresetn) begin
      next_r = '0;
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  // steps of a timed apply, shared by the properties below
  sequence s_link_event;
    event_strobe && event_use_link && !event_busy;
  endsequence
  sequence s_busy_then_free;
    event_busy ##1 !event_busy;
  endsequence

  // words move only together, and never closer than the step time
  a_words_atomic: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(r.live) |-> $past(fire))
    else $error("words moved without event");
  a_step_spacing: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fire |=> !fire)
    else $error("apply closer than step time");
  a_busy_window: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fire |=> s_busy_then_free)
    else $error("busy window wrong");
  a_gap_whole: assert property (
    @(posedge aclk) disable iff (!aresetn)
    event_busy |=> !event_busy)
    else $error("busy window not one cycle");
  a_drop_busy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (event_strobe && event_busy) |=>
      $stable(r.live) && r.drop_cnt == $past(r.drop_cnt) + 16'h1)
    else $error("busy event not dropped");

  // event and software applies load the right words in one edge
  a_load_one: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_link_event |=> r.live == $past(event_words))
    else $error("event words not loaded");
  a_freq_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (fire && !(event_strobe && event_use_link)) |=>
      freq_word == $past(r.stage.freq))
    else $error("staged tuning word not applied");
  a_phase_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !fire |=> $stable(phase_word))
    else $error("phase moved without apply");
  a_count_grid: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fire |=> r.apply_cnt == $past(r.apply_cnt) + 16'h1)
    else $error("apply count off");

  // the pulse marks the one cycle in which the words just moved
  a_pulse_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fire |=> apply_pulse)
    else $error("apply pulse missing");
  a_amp_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(amplitude_modulator_word) |-> apply_pulse)
    else $error("amp moved alone");
  a_pwr_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(power_level_word) |-> apply_pulse)
    else $error("power moved alone");

  // bus answers come on time and stand until the master takes them
  a_write_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule
`default_nettype wire

/* tb/rss_prog_model.sv */
// pulse programmer model: sends timed setting events
// assumes it shares aclk with the sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_prog_model (
  input  wire logic        aclk,     // core clock
  output rss_pkg::rss_set_t words,   // event words
  output logic             strobe,   // event pulse
  output logic             use_link  // take link words
);
  import rss_pkg::*;
  // idle at time zero
  initial begin
    strobe = 1'b0;
    words = '0;
    use_link = 1'b0;
  end
  // n strobes on adjacent edges; n above one breaks spacing on purpose
  task automatic send(input rss_set_t w, input logic l, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      strobe   <= 1'b1;
      words    <= w + i;
      use_link <= l;
    end
    @(posedge aclk);
    strobe <= 1'b0;
    words  <= ~(w + n - 1); // stale words are not held
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// testbench: axi4-lite and event traffic into the sequencer
// assumes rss_cfg.svh offsets and the programmer model
`timescale 1ns/1ps
`default_nettype none
`include "rss_cfg.svh"
module tb;
  import rss_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0] rsp;
  logic awr, wr, bv, arr, rv, st, ul, busy, ap;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  rss_set_t ew, w1, w2;
  rss_freq_t fw;
  rss_phase_t pw;
  rss_amp_t mw;
  rss_pwr_t lw;
  int mismatches = 0, total_checks = 0;
  // 10 MHz bench clock
  always #50 aclk = ~aclk;
  rss_prog_model rss_prog_model_i (.aclk(aclk), .words(ew), .strobe(st),
    .use_link(ul));
  rss_sequencer rss_sequencer_i (.aclk(aclk), .aresetn(aresetn),
    .event_strobe(st), .event_words(ew), .event_use_link(ul),
    .event_busy(busy), .freq_word(fw), .phase_word(pw),
    .amplitude_modulator_word(mw), .power_level_word(lw), .apply_pulse(ap),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry));
  task automatic chk(input logic [80:0] got, input logic [80:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = br;
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd = rdat;
    rsp = rr;
    rry <= 1'b0;
  endtask
  task automatic live(input rss_set_t e);
    @(negedge aclk);
    chk({fw, pw, mw, lw}, e);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    test_done;
  end
  initial begin
    w1 = {34'h3_89AB_CDEF, 16'h8001, 16'hFFFF, 15'h7FFF};
    w2 = {34'h1_2345_6789, 16'hA5A5, 16'h5A5A, 15'h1234};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    live('0);
    $display("reset test done");
    // staged words stay hidden until the apply write
    axw(`RSS_AXI_FREQ_LO, 32'h89AB_CDEF);
    axw(`RSS_AXI_FREQ_HI, 32'hFFFF_FFFF);
    axw(`RSS_AXI_PHASE, 32'h0001_8001);
    axw(`RSS_AXI_AMP, 32'hFFFF_FFFF);
    axw(`RSS_AXI_PWR, 32'hFFFF_FFFF);
    live('0);
    axw(`RSS_AXI_CTRL, 32'h1);
    live(w1);
    axr(`RSS_AXI_FREQ_HI);
    chk(rd, 32'h3);
    $display("staging test done");
    rss_prog_model_i.send(w2, 1'b1, 1);
    live(w2);
    chk(busy, 1'b1);
    chk(ap, 1'b1);
    rss_prog_model_i.send(w1, 1'b1, 2);
    live(w1);
    chk(busy, 1'b0);
    chk(ap, 1'b0);
    rss_prog_model_i.send(w2, 1'b1, 1);
    live(w2);
    rss_prog_model_i.send(w2, 1'b0, 1);
    live(w1);
    axr(`RSS_AXI_STAT);
    chk(rd, {16'h1, 16'h5});
    $display("event test done");
    axr(8'h1C);
    chk({rsp, rd}, {2'b10, 32'h0});
    axw(8'h1C, 32'h1);
    chk(rsp, 2'b10);
    $display("unmapped test done");
    test_done;
  end
endmodule
`default_nettype wire
